// ==== core/lbs_pkg.sv ====
package lbs_pkg;
    // Receive-buffer status encoding.
    localparam int BUF_STAT_W = 6;
    localparam int FREE_CNT_W = 8;
    localparam logic [5:0] STAT_SATURATE = 6'h1E;
    // Acknowledgement identifier widths for short and long control symbols.
    localparam int ACKID_W = 6;
    localparam logic [5:0] ACKID_MASK_SHORT = 6'h1F;
    localparam logic [5:0] ACKID_MASK_LONG = 6'h3F;
    localparam int ACKID_LSB = 58;
    // Stream and configuration port widths.
    localparam int TDATA_W = 64;
    localparam int TKEEP_W = 8;
    localparam int TUSER_W = 8;
    localparam int CFG_ADDR_W = 24;
    localparam int CFG_DATA_W = 32;
    localparam int CFG_STRB_W = 4;
    // Configuration space.
    localparam logic [23:0] CTRL_OFFSET = 24'h00_0000;
    localparam logic [23:0] STATUS_OFFSET = 24'h00_0004;
    localparam int CTRL_TX_FC_BIT = 0;
    localparam int CTRL_LONG_SYM_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Packet CRC.
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    // Link training settle time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRAIN_TIME_NS = 1000;
    localparam int TRAIN_CYCLES = (TRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum {LINK_DOWN, LINK_TRAINING, LINK_UP} lbs_link_type;
endpackage

// ==== core/lbs_stat_enc.sv ====
`timescale 1ns/1ps
// Encodes the count of free receive locations onto the status bus.
module lbs_stat_enc #(
    parameter int FREE_W = lbs_pkg::FREE_CNT_W
) (
    input wire logic [FREE_W-1:0] free_count,
    output logic [lbs_pkg::BUF_STAT_W-1:0] stat
);
    wire logic saturate;
    assign saturate = free_count > FREE_W'(lbs_pkg::STAT_SATURATE);
    // Values up to 30 never reach all ones in the low five bits nor in the whole bus.
    assign stat = saturate ? lbs_pkg::STAT_SATURATE
                           : lbs_pkg::BUF_STAT_W'(free_count);
endmodule // lbs_stat_enc

// ==== core/lbs_link_buffer.sv ====
`timescale 1ns/1ps
module lbs_link_buffer #(
    parameter int FREE_W = lbs_pkg::FREE_CNT_W,
    parameter int TRAIN_CYC = lbs_pkg::TRAIN_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_reset,
    input wire logic lanes_aligned,
    input wire logic [FREE_W-1:0] rx_free_count,
    output logic [lbs_pkg::BUF_STAT_W-1:0] phy_buf_stat,
    output logic tx_flow_control,
    output logic long_symbol_mode,
    output logic link_up,
    // Outgoing packets from the buffer toward the serial side.
    input wire logic s_txb_tvalid,
    output logic s_txb_tready,
    input wire logic [lbs_pkg::TDATA_W-1:0] s_txb_tdata,
    input wire logic [lbs_pkg::TKEEP_W-1:0] s_txb_tkeep,
    input wire logic s_txb_tlast,
    input wire logic [lbs_pkg::TUSER_W-1:0] s_txb_tuser,
    output logic m_txl_tvalid,
    input wire logic m_txl_tready,
    output logic [lbs_pkg::TDATA_W-1:0] m_txl_tdata,
    output logic [lbs_pkg::TKEEP_W-1:0] m_txl_tkeep,
    output logic m_txl_tlast,
    output logic [lbs_pkg::TUSER_W-1:0] m_txl_tuser,
    // Incoming packets from the serial side toward the buffer.
    input wire logic s_rxl_tvalid,
    output logic s_rxl_tready,
    input wire logic [lbs_pkg::TDATA_W-1:0] s_rxl_tdata,
    input wire logic [lbs_pkg::TKEEP_W-1:0] s_rxl_tkeep,
    input wire logic s_rxl_tlast,
    input wire logic [lbs_pkg::TUSER_W-1:0] s_rxl_tuser,
    output logic m_rxb_tvalid,
    input wire logic m_rxb_tready,
    output logic [lbs_pkg::TDATA_W-1:0] m_rxb_tdata,
    output logic [lbs_pkg::TKEEP_W-1:0] m_rxb_tkeep,
    output logic m_rxb_tlast,
    output logic [lbs_pkg::TUSER_W-1:0] m_rxb_tuser,
    // Configuration port.
    input wire logic s_axi_cfgb_awvalid,
    output logic s_axi_cfgb_awready,
    input wire logic [lbs_pkg::CFG_ADDR_W-1:0] s_axi_cfgb_awaddr,
    input wire logic s_axi_cfgb_wvalid,
    output logic s_axi_cfgb_wready,
    input wire logic [lbs_pkg::CFG_DATA_W-1:0] s_axi_cfgb_wdata,
    input wire logic [lbs_pkg::CFG_STRB_W-1:0] s_axi_cfgb_wstrb,
    output logic s_axi_cfgb_bvalid,
    input wire logic s_axi_cfgb_bready,
    output logic [1:0] s_axi_cfgb_bresp,
    input wire logic s_axi_cfgb_arvalid,
    output logic s_axi_cfgb_arready,
    input wire logic [lbs_pkg::CFG_ADDR_W-1:0] s_axi_cfgb_araddr,
    output logic s_axi_cfgb_rvalid,
    input wire logic s_axi_cfgb_rready,
    output logic [lbs_pkg::CFG_DATA_W-1:0] s_axi_cfgb_rdata,
    output logic [1:0] s_axi_cfgb_rresp
);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc16_beat(input logic [15:0] crc_in,
                                               input logic [63:0] data);
        logic [15:0] crc;
        crc = crc_in;
        for (int i = 63; i >= 0; i--) begin
            crc = crc[15] ^ data[i] ? ({crc[14:0], 1'b0} ^ lbs_pkg::CRC_POLY)
                                    : {crc[14:0], 1'b0};
        end
        return crc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic sync_a;
    logic rst_sync_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            sync_a <= 1'b1;
            rst_sync_n <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link training: lanes must stay aligned for the settle time.
    lbs_pkg::lbs_link_type link_state;
    lbs_pkg::lbs_link_type next_link_state;
    logic [15:0] train_count;
    wire logic train_done;
    assign train_done = train_count >= 16'(TRAIN_CYC - 1);
    always_comb begin
        case (link_state)
            lbs_pkg::LINK_DOWN: begin
                next_link_state = lanes_aligned ? lbs_pkg::LINK_TRAINING : lbs_pkg::LINK_DOWN;
            end
            lbs_pkg::LINK_TRAINING: begin
                if (!lanes_aligned) begin
                    next_link_state = lbs_pkg::LINK_DOWN;
                end else begin
                    next_link_state = train_done ? lbs_pkg::LINK_UP : lbs_pkg::LINK_TRAINING;
                end
            end
            lbs_pkg::LINK_UP: begin
                next_link_state = lanes_aligned ? lbs_pkg::LINK_UP : lbs_pkg::LINK_DOWN;
            end
            default: begin
                next_link_state = lbs_pkg::LINK_DOWN;
            end
        endcase
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            link_state <= lbs_pkg::LINK_DOWN;
            train_count <= 16'h0000;
            link_up <= 1'b0;
        end else begin
            link_state <= next_link_state;
            train_count <= link_state == lbs_pkg::LINK_TRAINING ? train_count + 16'h0001
                                                                 : 16'h0000;
            link_up <= next_link_state == lbs_pkg::LINK_UP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers and AXI4-Lite slave.
    logic [1:0] ctrl;
    logic [lbs_pkg::ACKID_W-1:0] tx_ackid;
    wire logic wr_take;
    wire logic rd_take;
    wire logic wr_hit;
    wire logic [lbs_pkg::CFG_DATA_W-1:0] rd_value;
    wire logic rd_hit;
    assign wr_take = s_axi_cfgb_awvalid && s_axi_cfgb_wvalid && !s_axi_cfgb_awready
                     && !s_axi_cfgb_bvalid && !cfg_reset;
    assign rd_take = s_axi_cfgb_arvalid && !s_axi_cfgb_arready && !s_axi_cfgb_rvalid
                     && !cfg_reset;
    assign wr_hit = s_axi_cfgb_awaddr == lbs_pkg::CTRL_OFFSET
                    || s_axi_cfgb_awaddr == lbs_pkg::STATUS_OFFSET;
    assign rd_hit = s_axi_cfgb_araddr == lbs_pkg::CTRL_OFFSET
                    || s_axi_cfgb_araddr == lbs_pkg::STATUS_OFFSET;
    assign rd_value = s_axi_cfgb_araddr == lbs_pkg::CTRL_OFFSET ? {30'h0000_0000, ctrl}
                    : {10'h000, tx_ackid, 2'h0, phy_buf_stat, 6'h00, link_up,
                       link_state == lbs_pkg::LINK_TRAINING};
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl <= lbs_pkg::CTRL_RESET;
            s_axi_cfgb_awready <= 1'b0;
            s_axi_cfgb_wready <= 1'b0;
            s_axi_cfgb_bvalid <= 1'b0;
            s_axi_cfgb_bresp <= lbs_pkg::RESP_OKAY;
            s_axi_cfgb_arready <= 1'b0;
            s_axi_cfgb_rvalid <= 1'b0;
            s_axi_cfgb_rdata <= 32'h0000_0000;
            s_axi_cfgb_rresp <= lbs_pkg::RESP_OKAY;
        end else if (cfg_reset) begin
            ctrl <= lbs_pkg::CTRL_RESET;
            s_axi_cfgb_awready <= 1'b0;
            s_axi_cfgb_wready <= 1'b0;
            s_axi_cfgb_bvalid <= 1'b0;
            s_axi_cfgb_arready <= 1'b0;
            s_axi_cfgb_rvalid <= 1'b0;
        end else begin
            s_axi_cfgb_awready <= wr_take;
            s_axi_cfgb_wready <= wr_take;
            s_axi_cfgb_arready <= rd_take;
            if (wr_take && s_axi_cfgb_awaddr == lbs_pkg::CTRL_OFFSET && s_axi_cfgb_wstrb[0]) begin
                ctrl <= s_axi_cfgb_wdata[1:0];
            end
            if (wr_take) begin
                s_axi_cfgb_bvalid <= 1'b1;
                s_axi_cfgb_bresp <= wr_hit ? lbs_pkg::RESP_OKAY : lbs_pkg::RESP_SLVERR;
            end else if (s_axi_cfgb_bready) begin
                s_axi_cfgb_bvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_cfgb_rvalid <= 1'b1;
                s_axi_cfgb_rdata <= rd_hit ? rd_value : 32'h0000_0000;
                s_axi_cfgb_rresp <= rd_hit ? lbs_pkg::RESP_OKAY : lbs_pkg::RESP_SLVERR;
            end else if (s_axi_cfgb_rready) begin
                s_axi_cfgb_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer status toward the link side.
    wire logic [lbs_pkg::BUF_STAT_W-1:0] next_buf_stat;
    lbs_stat_enc #(.FREE_W(FREE_W)) u_stat_enc (
        .free_count(rx_free_count),
        .stat(next_buf_stat)
    );
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phy_buf_stat <= 6'h00;
            tx_flow_control <= 1'b0;
            long_symbol_mode <= 1'b0;
        end else begin
            phy_buf_stat <= next_buf_stat;
            tx_flow_control <= ctrl[lbs_pkg::CTRL_TX_FC_BIT];
            long_symbol_mode <= ctrl[lbs_pkg::CTRL_LONG_SYM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit stream: ackID into the first beat, CRC into the low half-word of the last.
    logic [15:0] tx_crc;
    logic tx_first;
    wire logic tx_take;
    wire logic next_tx_valid;
    wire logic [lbs_pkg::ACKID_W-1:0] ackid_mask;
    wire logic [lbs_pkg::TDATA_W-1:0] tx_stamped;
    wire logic [lbs_pkg::TDATA_W-1:0] tx_crc_data;
    wire logic [15:0] tx_crc_next;
    assign tx_take = s_txb_tvalid && s_txb_tready;
    assign next_tx_valid = tx_take || (m_txl_tvalid && !m_txl_tready);
    assign ackid_mask = long_symbol_mode ? lbs_pkg::ACKID_MASK_LONG
                                         : lbs_pkg::ACKID_MASK_SHORT;
    assign tx_stamped = tx_first ? {tx_ackid & ackid_mask, s_txb_tdata[lbs_pkg::ACKID_LSB-1:0]}
                                 : s_txb_tdata;
    assign tx_crc_data = s_txb_tlast ? {tx_stamped[63:16], 16'h0000} : tx_stamped;
    assign tx_crc_next = crc16_beat(tx_first ? lbs_pkg::CRC_INIT : tx_crc, tx_crc_data);
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_txb_tready <= 1'b0;
            m_txl_tvalid <= 1'b0;
            m_txl_tdata <= 64'h0000_0000_0000_0000;
            m_txl_tkeep <= 8'h00;
            m_txl_tlast <= 1'b0;
            m_txl_tuser <= 8'h00;
            tx_ackid <= 6'h00;
            tx_crc <= lbs_pkg::CRC_INIT;
            tx_first <= 1'b1;
        end else begin
            s_txb_tready <= link_up && !next_tx_valid;
            m_txl_tvalid <= next_tx_valid;
            if (tx_take) begin
                m_txl_tdata <= s_txb_tlast ? {tx_stamped[63:16], tx_crc_next}
                                           : tx_stamped;
                m_txl_tkeep <= s_txb_tkeep;
                m_txl_tlast <= s_txb_tlast;
                m_txl_tuser <= s_txb_tuser;
                tx_crc <= tx_crc_next;
                tx_first <= s_txb_tlast;
                if (s_txb_tlast) begin
                    tx_ackid <= (tx_ackid + 6'h01) & ackid_mask;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive stream toward the buffer.
    wire logic rx_take;
    wire logic next_rx_valid;
    assign rx_take = s_rxl_tvalid && s_rxl_tready;
    assign next_rx_valid = rx_take || (m_rxb_tvalid && !m_rxb_tready);
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_rxl_tready <= 1'b0;
            m_rxb_tvalid <= 1'b0;
            m_rxb_tdata <= 64'h0000_0000_0000_0000;
            m_rxb_tkeep <= 8'h00;
            m_rxb_tlast <= 1'b0;
            m_rxb_tuser <= 8'h00;
        end else begin
            s_rxl_tready <= link_up && !next_rx_valid;
            m_rxb_tvalid <= next_rx_valid;
            if (rx_take) begin
                m_rxb_tdata <= s_rxl_tdata;
                m_rxb_tkeep <= s_rxl_tkeep;
                m_rxb_tlast <= s_rxl_tlast;
                m_rxb_tuser <= s_rxl_tuser;
            end
        end
    end
endmodule // lbs_link_buffer

// ==== tb/lbs_monitor.sv ====
`timescale 1ns/1ps
module lbs_monitor #(
    parameter int FREE_W = lbs_pkg::FREE_CNT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_reset,
    input wire logic [FREE_W-1:0] rx_free_count,
    input wire logic [5:0] phy_buf_stat,
    input wire logic tx_flow_control,
    input wire logic long_symbol_mode,
    input wire logic s_axi_cfgb_awvalid,
    input wire logic s_axi_cfgb_awready,
    input wire logic [23:0] s_axi_cfgb_awaddr,
    input wire logic s_axi_cfgb_wvalid,
    input wire logic [31:0] s_axi_cfgb_wdata,
    input wire logic [3:0] s_axi_cfgb_wstrb,
    input wire logic s_axi_cfgb_bvalid,
    input wire logic s_axi_cfgb_bready,
    input wire logic [1:0] s_axi_cfgb_bresp,
    input wire logic s_axi_cfgb_arvalid,
    input wire logic s_axi_cfgb_arready,
    input wire logic s_axi_cfgb_rvalid,
    input wire logic m_txl_tvalid,
    input wire logic m_txl_tready,
    input wire logic [63:0] m_txl_tdata
);
    logic [1:0] up_cnt;
    logic wr_take, wr_ok;
    logic [5:0] stat_exp;
    assign wr_take = s_axi_cfgb_awvalid && s_axi_cfgb_wvalid && !s_axi_cfgb_awready
        && !s_axi_cfgb_bvalid && !cfg_reset;
    assign wr_ok = s_axi_cfgb_awaddr == lbs_pkg::CTRL_OFFSET
        || s_axi_cfgb_awaddr == lbs_pkg::STATUS_OFFSET;
    assign stat_exp = (rx_free_count > lbs_pkg::STAT_SATURATE) ? lbs_pkg::STAT_SATURATE
        : rx_free_count[5:0];
    // The status bus is only compared with the estimate once the internal reset copy has been released.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    stat_not_ones_a: assert property (phy_buf_stat != 6'h3F)
        else $error("status bus all ones");
    stat_low_five_a: assert property (phy_buf_stat[4:0] != 5'h1F)
        else $error("status bus low five bits set");
    stat_value_a: assert property (up_cnt == 2'h3 |-> phy_buf_stat == $past(stat_exp))
        else $error("status bus wrong estimate");
    mode_follow_a: assert property (wr_take && s_axi_cfgb_awaddr == 24'h00_0000
        && s_axi_cfgb_wstrb[0] ##1 !cfg_reset |=> tx_flow_control == $past(s_axi_cfgb_wdata[0], 2)
        && long_symbol_mode == $past(s_axi_cfgb_wdata[1], 2)) else $error("mode outputs wrong");
    ctrl_clear_a: assert property (cfg_reset |-> ##2 !tx_flow_control && !long_symbol_mode)
        else $error("modes kept through reset");
    quiet_reset_a: assert property (cfg_reset |=> !s_axi_cfgb_awready && !s_axi_cfgb_bvalid
        && !s_axi_cfgb_arready && !s_axi_cfgb_rvalid) else $error("handshake during reset");
    write_answer_a: assert property (wr_take |=> s_axi_cfgb_awready && s_axi_cfgb_bvalid
        && s_axi_cfgb_bresp == ($past(wr_ok) ? lbs_pkg::RESP_OKAY : lbs_pkg::RESP_SLVERR))
        else $error("write answer wrong");
    bresp_hold_a: assert property (s_axi_cfgb_bvalid && !s_axi_cfgb_bready
        |=> s_axi_cfgb_bvalid && $stable(s_axi_cfgb_bresp)) else $error("write response lost");
    read_answer_a: assert property (s_axi_cfgb_arvalid && !s_axi_cfgb_arready
        && !s_axi_cfgb_rvalid && !cfg_reset |=> s_axi_cfgb_arready && s_axi_cfgb_rvalid)
        else $error("read answer missing");
    txl_hold_a: assert property (m_txl_tvalid && !m_txl_tready
        |=> m_txl_tvalid && $stable(m_txl_tdata)) else $error("stream beat not held");
    cover property (wr_take && !wr_ok);
    cover property (cfg_reset && s_axi_cfgb_arvalid);
    cover property (m_txl_tvalid && !m_txl_tready);
    cover property (up_cnt == 2'h3 && rx_free_count > lbs_pkg::STAT_SATURATE);
endmodule // lbs_monitor

bind lbs_link_buffer lbs_monitor #(.FREE_W(FREE_W)) mon_u (.clock, .rst_n, .cfg_reset,
    .rx_free_count, .phy_buf_stat, .tx_flow_control, .long_symbol_mode, .s_axi_cfgb_awvalid,
    .s_axi_cfgb_awready, .s_axi_cfgb_awaddr, .s_axi_cfgb_wvalid, .s_axi_cfgb_wdata,
    .s_axi_cfgb_wstrb, .s_axi_cfgb_bvalid, .s_axi_cfgb_bready, .s_axi_cfgb_bresp,
    .s_axi_cfgb_arvalid, .s_axi_cfgb_arready, .s_axi_cfgb_rvalid, .m_txl_tvalid,
    .m_txl_tready, .m_txl_tdata);

// ==== tb/lbs_far_model.sv ====
`timescale 1ns/1ps
// Link side: aligns the lanes, drains outgoing beats and sources incoming ones.
module lbs_far_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow,
    output logic lanes_aligned,
    input wire logic m_txl_tvalid,
    output logic m_txl_tready,
    input wire logic [63:0] m_txl_tdata,
    output logic s_rxl_tvalid,
    input wire logic s_rxl_tready,
    output logic [63:0] s_rxl_tdata,
    output logic [7:0] s_rxl_tkeep,
    output logic s_rxl_tlast,
    output logic [7:0] s_rxl_tuser
);
    logic [63:0] got [8];
    int n_got;
    initial begin
        lanes_aligned = 1'b0;
        m_txl_tready = 1'b0;
        n_got = 0;
        s_rxl_tvalid = 1'b0;
        s_rxl_tdata = '0;
        s_rxl_tkeep = 8'hFF;
        s_rxl_tlast = 1'b1;
        s_rxl_tuser = 8'h00;
    end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lanes_aligned <= 1'b0;
            m_txl_tready <= 1'b0;
            n_got <= 0;
        end else begin
            lanes_aligned <= 1'b1;
            m_txl_tready <= slow ? ~m_txl_tready : 1'b1;
            if (m_txl_tvalid && m_txl_tready && n_got < 8) begin
                got[n_got] <= m_txl_tdata;
                n_got <= n_got + 1;
            end
        end
    end
    task automatic send_rx(input logic [63:0] d);
        int n;
        n = 0;
        s_rxl_tdata <= d;
        s_rxl_tvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (s_rxl_tready !== 1'b1 && n < 50);
        s_rxl_tvalid <= 1'b0;
        s_rxl_tdata <= ~d;
    endtask
endmodule // lbs_far_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam logic [63:0] D0 = 64'hFC00_1234_5678_9ABC;
    localparam logic [63:0] D1 = 64'h0F0F_F0F0_3C3C_C3C3;
    logic clock = 1'b0, rst_n = 1'b0, cfg_reset = 1'b0, slow = 1'b0;
    logic [7:0] rx_free_count = '0, s_txb_tkeep = 8'hFF, s_txb_tuser = '0;
    logic s_txb_tvalid = 1'b0, s_txb_tlast = 1'b0, m_rxb_tready = 1'b0;
    logic [63:0] s_txb_tdata = '0, m_txl_tdata, s_rxl_tdata, m_rxb_tdata;
    logic lanes_aligned, s_txb_tready, m_txl_tvalid, m_txl_tready, m_txl_tlast, link_up;
    logic tx_flow_control, long_symbol_mode, s_rxl_tvalid, s_rxl_tready, s_rxl_tlast;
    logic m_rxb_tvalid, m_rxb_tlast;
    logic [5:0] phy_buf_stat;
    logic [7:0] m_txl_tkeep, m_txl_tuser, s_rxl_tkeep, s_rxl_tuser, m_rxb_tkeep, m_rxb_tuser;
    logic s_axi_cfgb_awvalid = 1'b0, s_axi_cfgb_wvalid = 1'b0, s_axi_cfgb_bready = 1'b0;
    logic s_axi_cfgb_arvalid = 1'b0, s_axi_cfgb_rready = 1'b1;
    logic [23:0] s_axi_cfgb_awaddr = '0, s_axi_cfgb_araddr = '0;
    logic [31:0] s_axi_cfgb_wdata = '0, s_axi_cfgb_rdata;
    logic [3:0] s_axi_cfgb_wstrb = '0;
    logic s_axi_cfgb_awready, s_axi_cfgb_wready, s_axi_cfgb_bvalid;
    logic s_axi_cfgb_arready, s_axi_cfgb_rvalid;
    logic [1:0] s_axi_cfgb_bresp, s_axi_cfgb_rresp;
    int n_mismatch = 0, checks = 0, cyc = 0;
    lbs_link_buffer #(.TRAIN_CYC(4)) dut_u (.*);
    lbs_far_model far_u (.*);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [71:0] exp, input logic [71:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [63:0] d);
        for (int i = 63; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? lbs_pkg::CRC_POLY : 16'h0000);
        end
        return c;
    endfunction
    task automatic axi_wr(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int n;
        n = 0;
        s_axi_cfgb_awaddr <= a;
        s_axi_cfgb_wdata <= d;
        s_axi_cfgb_wstrb <= s;
        s_axi_cfgb_awvalid <= 1'b1;
        s_axi_cfgb_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (s_axi_cfgb_awready !== 1'b1 && n < 20);
        cmp("wr_accept", 1, {s_axi_cfgb_wready, s_axi_cfgb_bvalid} == 2'b11);
        r = s_axi_cfgb_bresp;
        s_axi_cfgb_awvalid <= 1'b0;
        s_axi_cfgb_wvalid <= 1'b0;
        @(posedge clock);
        s_axi_cfgb_bready <= 1'b1;
        @(posedge clock);
        s_axi_cfgb_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [23:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_cfgb_araddr <= a;
        s_axi_cfgb_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (s_axi_cfgb_arready !== 1'b1 && n < 20);
        cmp("rd_accept", 1, s_axi_cfgb_rvalid);
        d = s_axi_cfgb_rdata;
        r = s_axi_cfgb_rresp;
        s_axi_cfgb_arvalid <= 1'b0;
        @(posedge clock);
    endtask
    task automatic tx_beat(input logic [63:0] d, input logic l);
        int n;
        n = 0;
        s_txb_tdata <= d;
        s_txb_tlast <= l;
        s_txb_tvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (s_txb_tready !== 1'b1 && n < 50);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_status();
        logic [7:0] v [8] = '{8'h00, 8'h01, 8'h1D, 8'h1E, 8'h1F, 8'h3F, 8'h7F, 8'hFF};
        for (int i = 0; i < 8; i++) begin
            rx_free_count <= v[i];
            repeat (2) @(posedge clock);
            cmp("buf_stat", (v[i] > 8'h1E) ? 8'h1E : v[i], phy_buf_stat);
        end
    endtask
    task automatic t_mode();
        logic [1:0] r;
        logic [31:0] d;
        for (int v = 0; v < 4; v++) begin
            axi_wr(24'h00_0000, 32'(v), 4'h1, r);
            cmp("mode_wr", {lbs_pkg::RESP_OKAY, 2'(v)}, {r, long_symbol_mode, tx_flow_control});
            axi_rd(lbs_pkg::CTRL_OFFSET, d, r);
            cmp("ctrl_rd", v, d);
        end
        axi_wr(24'h00_0000, 32'h0000_0000, 4'hE, r);
        cmp("masked_wr", 1, tx_flow_control);
        axi_wr(24'h00_0010, 32'h0000_0003, 4'hF, r);
        cmp("bad_wr", lbs_pkg::RESP_SLVERR, r);
        axi_rd(24'h00_0010, d, r);
        cmp("bad_rd", {lbs_pkg::RESP_SLVERR, 32'h0000_0000}, {r, d});
        axi_rd(lbs_pkg::STATUS_OFFSET, d, r);
        cmp("status_rd", {2'h0, 6'h1E, 1'b1}, {r, d[13:8], d[1]});
    endtask
    task automatic t_cfgrst();
        logic [1:0] r;
        logic [31:0] d;
        axi_wr(24'h00_0000, 32'h0000_0003, 4'h1, r);
        // The read request is held through the reset and is answered once it ends.
        cfg_reset <= 1'b1;
        s_axi_cfgb_araddr <= lbs_pkg::CTRL_OFFSET;
        s_axi_cfgb_arvalid <= 1'b1;
        repeat (3) @(posedge clock);
        cmp("in_reset", 0, {s_axi_cfgb_arready, s_axi_cfgb_rvalid});
        cmp("modes_cleared", 0, {tx_flow_control, long_symbol_mode});
        cfg_reset <= 1'b0;
        axi_rd(lbs_pkg::CTRL_OFFSET, d, r);
        cmp("ctrl_reset", lbs_pkg::CTRL_RESET, d[1:0]);
    endtask
    task automatic t_tx();
        logic [1:0] r;
        logic [63:0] f;
        logic [15:0] e;
        for (int n = 0; n < 100 && link_up !== 1'b1; n++) @(posedge clock);
        cmp("link_up", 1, link_up);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) axi_wr(24'h00_0000, 32'h0000_0002, 4'h1, r);
            slow <= (k != 0);
            tx_beat(D0, 1'b0);
            tx_beat(D1, 1'b1);
            s_txb_tvalid <= 1'b0;
            s_txb_tdata <= ~D1;
            for (int n = 0; n < 50 && far_u.n_got != 2 * k + 2; n++) @(posedge clock);
            f = {6'(k), D0[57:0]};
            cmp("ack_stamp", f, far_u.got[2 * k]);
            e = crc_add(crc_add(lbs_pkg::CRC_INIT, f), {D1[63:16], 16'h0000});
            cmp("crc_stamp", {D1[63:16], e}, far_u.got[2 * k + 1]);
        end
        cmp("tx_side", {1'b1, 8'hFF, 8'h00}, {m_txl_tlast, m_txl_tkeep, m_txl_tuser});
    endtask
    task automatic t_rx();
        far_u.send_rx(D1);
        repeat (3) @(posedge clock);
        cmp("rx_held", {1'b1, D1}, {m_rxb_tvalid, m_rxb_tdata});
        cmp("rx_side", {1'b1, 8'hFF, 8'h00}, {m_rxb_tlast, m_rxb_tkeep, m_rxb_tuser});
        m_rxb_tready <= 1'b1;
        @(posedge clock);
        m_rxb_tready <= 1'b0;
        @(posedge clock);
        cmp("rx_taken", 0, m_rxb_tvalid);
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_status();
        t_mode();
        t_cfgrst();
        t_tx();
        t_rx();
        print_verdict();
    end
endmodule // tb
